// [verilog/speed_limit_pkg.sv]
// Purpose: constants shared by the torque-mode speed limiter
// Assumes: AHB-Lite register access, 32-bit data, one word per register
// Notes:   speeds are unsigned magnitudes in 1 rpm steps
package speed_limit_pkg;

    localparam int          SPEED_W              = 16;

    // register byte offsets
    localparam logic [7:0]  CTRL_OFFSET          = 8'h00;
    localparam logic [7:0]  INT_LIMIT_OFFSET     = 8'h04;
    localparam logic [7:0]  MOTOR_MAX_OFFSET     = 8'h08;
    localparam logic [7:0]  OVERSPEED_OFFSET     = 8'h0C;
    localparam logic [7:0]  STATUS_OFFSET        = 8'h10;

    // control register fields
    localparam int          CTRL_SOURCE_BIT      = 0;
    localparam int          CTRL_CEILING_BIT     = 1;
    localparam int          CTRL_APPLY_BIT       = 8;

    // status register fields
    localparam int          STAT_FLAG_BIT        = 0;
    localparam int          STAT_SOURCE_BIT      = 1;
    localparam int          STAT_CEILING_BIT     = 2;
    localparam int          STAT_LIMIT_LSB       = 16;

    // internal limit maximum and reset values
    localparam logic [15:0] INT_LIMIT_MAX        = 16'h2710;
    localparam logic [15:0] INT_LIMIT_RESET      = 16'h2710;
    localparam logic [15:0] MOTOR_MAX_RESET      = 16'h2710;
    localparam logic [15:0] OVERSPEED_RESET      = 16'h2AF8;
    localparam logic        SOURCE_RESET         = 1'b0;
    localparam logic        CEILING_RESET        = 1'b0;

    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ        = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ           = 2'h3;
    localparam logic        HRESP_OKAY           = 1'b0;

endpackage

// [verilog/torque_mode_speed_limiter.sv]
// Purpose: selects the active speed limit in torque control and flags limiting
// Assumes: speed, torque-mode and tick inputs come from logic on clk
// Notes:   zero-wait AHB-Lite slave; source and ceiling selects take effect
//          only at reset release or on a write with the apply bit set
//          registers: control (source, ceiling, apply), internal limit,
//          motor maximum, overspeed detection, status (read only)
//          status holds the flag, the active selects and the active limit
//          a read returns what the register holds in its data phase
//          limit changes only at a control tick; flag changes at a tick and also clears whenever torqueMode is low
//          speed magnitude is compared, so both directions limit alike
//          hsize is ignored, every access is a whole word
//          unmapped offsets read zero and ignore writes
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
module torque_mode_speed_limiter #(
    parameter int SPEED_W = speed_limit_pkg::SPEED_W
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 controlTick,
    input  wire logic                 torqueMode,
    input  wire logic signed [SPEED_W:0] motorSpeed,
    input  wire logic [SPEED_W-1:0]   externalSpeedLimitValue,
    output logic      [SPEED_W-1:0]   activeSpeedLimit,
    output logic                      speedLimitActiveFlag
);
    import speed_limit_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // register decode and helpers
    // register targets of an access
    typedef enum {
        REG_CTRL,
        REG_INT_LIMIT,
        REG_MOTOR_MAX,
        REG_OVERSPEED,
        REG_STATUS,
        REG_NONE
    } reg_e;

    // one address decode shared by the write and the read path
    function automatic reg_e decodeReg(input logic [7:0] a);
        unique case (a)
            CTRL_OFFSET:      decodeReg = REG_CTRL;
            INT_LIMIT_OFFSET: decodeReg = REG_INT_LIMIT;
            MOTOR_MAX_OFFSET: decodeReg = REG_MOTOR_MAX;
            OVERSPEED_OFFSET: decodeReg = REG_OVERSPEED;
            STATUS_OFFSET:    decodeReg = REG_STATUS;
            default:          decodeReg = REG_NONE;
        endcase
    endfunction

    // speed registers read back zero-extended
    function automatic logic [31:0] speedWord(input logic [SPEED_W-1:0] v);
        speedWord = 32'(v);
    endfunction

    function automatic logic [SPEED_W-1:0] clampLimit(input logic [31:0] w);
        clampLimit = w[SPEED_W-1:0];
        // upper bits set count as too large
        if (w[SPEED_W-1:0] > INT_LIMIT_MAX[SPEED_W-1:0] || |w[31:SPEED_W]) begin
            clampLimit = INT_LIMIT_MAX[SPEED_W-1:0];
        end
    endfunction

    function automatic logic [SPEED_W-1:0] minSpeed(input logic [SPEED_W-1:0] a,
                                                    input logic [SPEED_W-1:0] b);
        minSpeed = (a < b) ? a : b;
    endfunction

    // saturates the one negative value with no positive twin
    function automatic logic [SPEED_W-1:0] magnitude(input logic signed [SPEED_W:0] s);
        logic [SPEED_W:0] u;
        u = s[SPEED_W] ? (~s + 1'b1) : s;
        magnitude = u[SPEED_W] ? {SPEED_W{1'b1}} : u[SPEED_W-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase capture
    logic                 wrPending;
    logic                 rdPending;
    logic [7:0]           addrLatched;
    logic                 next_wrPending;
    logic                 next_rdPending;
    logic [7:0]           next_addrLatched;
    logic                 addrPhase;
    logic                 validTrans;

    // data phase follows the address phase by one clock
    assign validTrans = (htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ);
    assign addrPhase  = hsel && hready && validTrans;

    always_comb begin
        next_wrPending   = addrPhase && hwrite;
        next_rdPending   = addrPhase && !hwrite;
        // address held for the data phase
        next_addrLatched = addrPhase ? haddr[7:0] : addrLatched;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPending   <= 1'b0;
            rdPending   <= 1'b0;
            addrLatched <= 8'h00;
        end else begin
            wrPending   <= next_wrPending;
            rdPending   <= next_rdPending;
            addrLatched <= next_addrLatched;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic                 sourcePending;
    logic                 ceilingPending;
    logic                 sourceSel;
    logic                 ceilingSel;
    logic                 startupDone;
    logic [SPEED_W-1:0]   internalLimitSpeed;
    logic [SPEED_W-1:0]   motorMaxSpeed;
    logic [SPEED_W-1:0]   overspeedDetectSpeed;
    logic                 next_sourcePending;
    logic                 next_ceilingPending;
    logic                 next_sourceSel;
    logic                 next_ceilingSel;
    logic                 next_startupDone;
    logic [SPEED_W-1:0]   next_internalLimitSpeed;
    logic [SPEED_W-1:0]   next_motorMaxSpeed;
    logic [SPEED_W-1:0]   next_overspeedDetectSpeed;

    always_comb begin
        next_sourcePending        = sourcePending;
        next_ceilingPending       = ceilingPending;
        next_sourceSel            = sourceSel;
        next_ceilingSel           = ceilingSel;
        next_startupDone          = 1'b1;
        next_internalLimitSpeed   = internalLimitSpeed;
        next_motorMaxSpeed        = motorMaxSpeed;
        next_overspeedDetectSpeed = overspeedDetectSpeed;
        if (!startupDone) begin
            // selects load once after reset, like a restart
            next_sourceSel  = sourcePending;
            next_ceilingSel = ceilingPending;
        end
        if (wrPending) begin
            unique case (decodeReg(addrLatched))
                REG_CTRL: begin
                    next_sourcePending  = hwdata[CTRL_SOURCE_BIT];
                    next_ceilingPending = hwdata[CTRL_CEILING_BIT];
                    // apply bit copies the selects at once
                    if (hwdata[CTRL_APPLY_BIT]) begin
                        next_sourceSel  = hwdata[CTRL_SOURCE_BIT];
                        next_ceilingSel = hwdata[CTRL_CEILING_BIT];
                    end
                end
                REG_INT_LIMIT: next_internalLimitSpeed = clampLimit(hwdata);
                REG_MOTOR_MAX: next_motorMaxSpeed = hwdata[SPEED_W-1:0];
                REG_OVERSPEED: next_overspeedDetectSpeed = hwdata[SPEED_W-1:0];
                REG_STATUS: ;
                REG_NONE: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sourcePending        <= SOURCE_RESET;
            ceilingPending       <= CEILING_RESET;
            sourceSel            <= SOURCE_RESET;
            ceilingSel           <= CEILING_RESET;
            startupDone          <= 1'b0;
            internalLimitSpeed   <= INT_LIMIT_RESET[SPEED_W-1:0];
            motorMaxSpeed        <= MOTOR_MAX_RESET[SPEED_W-1:0];
            overspeedDetectSpeed <= OVERSPEED_RESET[SPEED_W-1:0];
        end else begin
            sourcePending        <= next_sourcePending;
            ceilingPending       <= next_ceilingPending;
            sourceSel            <= next_sourceSel;
            ceilingSel           <= next_ceilingSel;
            startupDone          <= next_startupDone;
            internalLimitSpeed   <= next_internalLimitSpeed;
            motorMaxSpeed        <= next_motorMaxSpeed;
            overspeedDetectSpeed <= next_overspeedDetectSpeed;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // limit selection and indication, once per control cycle
    logic [SPEED_W-1:0]   ceilingSpeed;
    logic [SPEED_W-1:0]   internalActive;
    logic [SPEED_W-1:0]   selectedLimit;
    logic [SPEED_W-1:0]   speedMag;
    logic                 atLimit;
    logic [SPEED_W-1:0]   next_activeSpeedLimit;
    logic                 next_speedLimitActiveFlag;

    always_comb begin
        // candidates, evaluated every clock
        // ceiling: motor maximum, or overspeed detection when ceilingSel is set
        ceilingSpeed = motorMaxSpeed;
        if (ceilingSel) begin
            ceilingSpeed = overspeedDetectSpeed;
        end
        internalActive = minSpeed(ceilingSpeed, internalLimitSpeed);
        selectedLimit = internalActive;
        if (sourceSel) begin
            selectedLimit = externalSpeedLimitValue;
        end
        speedMag = magnitude(motorSpeed);
        atLimit  = speedMag >= selectedLimit;
    end

    // limit register moves only at a tick; flag moves at a tick or clears when torqueMode is low
    always_comb begin
        next_activeSpeedLimit     = activeSpeedLimit;
        next_speedLimitActiveFlag = speedLimitActiveFlag;
        if (controlTick) begin
            next_activeSpeedLimit = selectedLimit;
            next_speedLimitActiveFlag = torqueMode && atLimit;
        end
        if (!torqueMode) begin
            next_speedLimitActiveFlag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            activeSpeedLimit     <= INT_LIMIT_RESET[SPEED_W-1:0];
            speedLimitActiveFlag <= 1'b0;
        end else begin
            activeSpeedLimit     <= next_activeSpeedLimit;
            speedLimitActiveFlag <= next_speedLimitActiveFlag;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered at the address phase
    // words come from next values, so a read right behind a write sees it
    logic [31:0]          ctrlWord;
    logic [31:0]          statusWord;
    logic [31:0]          next_hrdata;

    always_comb begin
        ctrlWord                              = 32'h0000_0000;
        ctrlWord[CTRL_SOURCE_BIT]             = next_sourcePending;
        ctrlWord[CTRL_CEILING_BIT]            = next_ceilingPending;
        statusWord                            = 32'h0000_0000;
        statusWord[STAT_FLAG_BIT]             = next_speedLimitActiveFlag;
        statusWord[STAT_SOURCE_BIT]           = next_sourceSel;
        statusWord[STAT_CEILING_BIT]          = next_ceilingSel;
        statusWord[STAT_LIMIT_LSB +: SPEED_W] = next_activeSpeedLimit;
    end

    always_comb begin
        // zero outside a read data phase
        next_hrdata = 32'h0000_0000;
        if (next_rdPending) begin
            unique case (decodeReg(haddr[7:0]))
                REG_CTRL:      next_hrdata = ctrlWord;
                REG_INT_LIMIT: next_hrdata = speedWord(next_internalLimitSpeed);
                REG_MOTOR_MAX: next_hrdata = speedWord(next_motorMaxSpeed);
                REG_OVERSPEED: next_hrdata = speedWord(next_overspeedDetectSpeed);
                REG_STATUS:    next_hrdata = statusWord;
                REG_NONE:      next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp     <= HRESP_OKAY;
        end else begin
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end
    end

endmodule

// [tb/speed_limiter_props.sv]
// Purpose: port-level checks of the speed limiter
// Assumes: hready is tied to hreadyout
// Notes:   bound onto every limiter instance
module speed_limiter_props #(
    parameter int SPEED_W = 16
) (
    input wire logic                      clk,
    input wire logic                      reset_n,
    input wire logic                      hsel,
    input wire logic [31:0]               haddr,
    input wire logic [1:0]                htrans,
    input wire logic                      hwrite,
    input wire logic                      hready,
    input wire logic [31:0]               hrdata,
    input wire logic                      hreadyout,
    input wire logic                      controlTick,
    input wire logic                      torqueMode,
    input wire logic signed [SPEED_W:0]   motorSpeed,
    input wire logic [SPEED_W-1:0]        activeSpeedLimit,
    input wire logic                      speedLimitActiveFlag
);
    timeunit 1ns;
    timeprecision 1ps;
    import speed_limit_pkg::*;
    logic             rdPhase;
    logic             rdStat;
    logic             next_rdPhase;
    logic             next_rdStat;
    logic [SPEED_W:0] mag;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    always_comb begin
        next_rdPhase = hsel && hready && htrans[1] && !hwrite;
        next_rdStat = next_rdPhase && (haddr[7:0] == STATUS_OFFSET);
        mag = motorSpeed[SPEED_W] ? -motorSpeed : motorSpeed;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdPhase <= 1'b0;
            rdStat <= 1'b0;
        end else begin
            rdPhase <= next_rdPhase;
            rdStat <= next_rdStat;
        end
    end
    ////////////////////////////////////////////////////////////
    a_flag_notorque: assert property (
        !torqueMode |=> !speedLimitActiveFlag) else $error("flag high outside torque control");
    a_flag_hold: assert property (
        torqueMode && !controlTick |=> $stable(speedLimitActiveFlag)) else $error("flag moved without tick");
    a_limit_hold: assert property (
        !controlTick |=> $stable(activeSpeedLimit)) else $error("limit moved without tick");
    a_flag_reach: assert property (
        controlTick && torqueMode |=> speedLimitActiveFlag == ($past(mag) >= activeSpeedLimit))
        else $error("flag disagrees with speed and limit");
    a_status_read: assert property (
        rdStat && $stable(activeSpeedLimit) && $stable(speedLimitActiveFlag)
        |-> hrdata[31:16] == activeSpeedLimit && hrdata[STAT_FLAG_BIT] == speedLimitActiveFlag)
        else $error("status read disagrees with outputs");
    a_reset_limit: assert property (
        !$past(reset_n) |-> activeSpeedLimit == INT_LIMIT_RESET) else $error("limit not default after reset");
    a_rdata_idle: assert property (
        !rdPhase |-> hrdata == 32'h0) else $error("read data outside data phase");
    a_ready_high: assert property (
        $past(reset_n) |-> hreadyout) else $error("slave inserted wait state");
    cover property (controlTick && torqueMode ##1 speedLimitActiveFlag);
    cover property (rdStat);
    cover property (!torqueMode ##1 !speedLimitActiveFlag);
endmodule
bind torque_mode_speed_limiter speed_limiter_props #(.SPEED_W(SPEED_W)) chk_u (.clk(clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .controlTick(controlTick), .torqueMode(torqueMode), .motorSpeed(motorSpeed),
    .activeSpeedLimit(activeSpeedLimit), .speedLimitActiveFlag(speedLimitActiveFlag));

// [tb/host_model.sv]
// Purpose: host side that hands the external limit to the drive
// Assumes: one clock shared with the drive
// Notes:   limit is registered, as a network update would be
module host_model (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] limitReq,
    output logic      [15:0] externalSpeedLimitValue
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            externalSpeedLimitValue <= 16'h0000;
        end else begin
            externalSpeedLimitValue <= limitReq;
        end
    end
endmodule

// [tb/torque_mode_speed_limiter_test.sv]
// Purpose: directed checks of the torque-mode speed limiter
// Assumes: zero-wait slave, hready tied to hreadyout
// Notes:   speeds in rpm
module torque_mode_speed_limiter_test;
    timeunit 1ns;
    timeprecision 1ps;
    import speed_limit_pkg::*;
    logic               clk, reset_n, hsel, hwrite, controlTick, torqueMode;
    logic               hreadyout, hresp, speedLimitActiveFlag;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    logic [1:0]         htrans;
    logic signed [16:0] motorSpeed;
    logic [15:0]        limitReq, externalSpeedLimitValue, activeSpeedLimit;
    int                 miscompares, tests_run;
    torque_mode_speed_limiter dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .controlTick(controlTick),
        .torqueMode(torqueMode), .motorSpeed(motorSpeed), .externalSpeedLimitValue(externalSpeedLimitValue),
        .activeSpeedLimit(activeSpeedLimit), .speedLimitActiveFlag(speedLimitActiveFlag));
    host_model host_u (.clk(clk), .reset_n(reset_n), .limitReq(limitReq),
        .externalSpeedLimitValue(externalSpeedLimitValue));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic tk(input logic signed [16:0] s, input logic m, input logic [15:0] lim, input logic f);
        @(posedge clk);
        motorSpeed <= s;
        torqueMode <= m;
        controlTick <= 1'b1;
        @(posedge clk);
        controlTick <= 1'b0;
        #1;
        chk({16'h0000, activeSpeedLimit}, {16'h0000, lim});
        chk({31'h0, speedLimitActiveFlag}, {31'h0, f});
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
    initial begin
        {reset_n, hsel, hwrite, controlTick, torqueMode} = 5'h00;
        {haddr, hwdata, htrans, motorSpeed, limitReq} = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(INT_LIMIT_OFFSET, 32'h00002710);
        rdchk(MOTOR_MAX_OFFSET, 32'h00002710);
        rdchk(OVERSPEED_OFFSET, 32'h00002AF8);
        rdchk(CTRL_OFFSET, 32'h00000000);
        rdchk(STATUS_OFFSET, 32'h27100000);
        rdchk(8'h14, 32'h00000000);
        xfer(1'b1, INT_LIMIT_OFFSET, 32'h00004E20);
        rdchk(INT_LIMIT_OFFSET, 32'h00002710);
        xfer(1'b1, INT_LIMIT_OFFSET, 32'h00000BB8);
        xfer(1'b1, MOTOR_MAX_OFFSET, 32'h000007D0);
        xfer(1'b1, OVERSPEED_OFFSET, 32'h000009C4);
        limitReq <= 16'h02BC;
        tk(17'sh005DC, 1'b1, 16'h07D0, 1'b0);
        tk(-17'sh009C4, 1'b1, 16'h07D0, 1'b1);
        tk(17'sh007D0, 1'b1, 16'h07D0, 1'b1);
        tk(17'sh009C4, 1'b0, 16'h07D0, 1'b0);
        xfer(1'b1, CTRL_OFFSET, 32'h00000002);
        tk(17'sh005DC, 1'b1, 16'h07D0, 1'b0);
        xfer(1'b1, CTRL_OFFSET, 32'h00000102);
        tk(17'sh009C4, 1'b1, 16'h09C4, 1'b1);
        rdchk(STATUS_OFFSET, 32'h09C40005);
        xfer(1'b1, INT_LIMIT_OFFSET, 32'h000003E8);
        tk(17'sh009C4, 1'b1, 16'h03E8, 1'b1);
        xfer(1'b1, CTRL_OFFSET, 32'h00000103);
        tk(17'sh001F4, 1'b1, 16'h02BC, 1'b0);
        tk(-17'sh002BC, 1'b1, 16'h02BC, 1'b1);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(STATUS_OFFSET, 32'h27100000);
        rdchk(CTRL_OFFSET, 32'h00000000);
        tk(17'sh002BC, 1'b1, 16'h2710, 1'b0);
        give_verdict;
    end
endmodule
